// [hw/tws_pkg.sv]
// Constants and types for the two-wire serial memory slave
// Summary of operation
// - Sample bits on clock rise, drive on fall
// - Data changes only while serial clock is low
// - Data falling, clock high: start condition
// - Data rising, clock high: stop, ends transaction
// - Stop ends read or launches programming cycle
// - Eight-bit words, receiver acknowledges ninth clock
// - Ack every write byte; read: address only
// - Master ack zero fetches next read byte
// - No ack, no stop: stay released, silent
// - Device word: type, chip field, direction
// - Chip field compared against strapped pins
// - Small variants reuse chip bits as address
// - Direction bit: zero write, one read
// - Match acknowledges; mismatch returns to standby
// - One or two address bytes, each acknowledged
// - Ignore bus until programming cycle completes
// - Extra bytes form page write, thirty-two max
// - Only five low offset bits increment, wrap
// - Lock pin high blocks upper array region
// - Reads unaffected by the lock pin
// - Programming ends within 10 or 15 ms
// - Busy device leaves device word unacknowledged
package tws_pkg;

    localparam int ADDR_W = 13;
    localparam int MEM_WORDS = 8192;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] LAST_DATA_BIT = 4'h7;
    localparam logic [BIT_CNT_W-1:0] ACK_BIT = 4'h8;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h0;

    // Device type code value is arbitrary
    localparam logic [3:0] DEV_TYPE_CODE = 4'h6;

    localparam logic [ADDR_W-1:0] MASK_8K = 13'h03FF;
    localparam logic [ADDR_W-1:0] MASK_16K = 13'h07FF;
    localparam logic [ADDR_W-1:0] MASK_32K = 13'h0FFF;
    localparam logic [ADDR_W-1:0] MASK_64K = 13'h1FFF;
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;

    localparam int SYS_CLK_MHZ = 250;
    localparam int PROG_TIME_HI_MS = 10;
    localparam int PROG_TIME_LO_MS = 15;
    localparam int PROG_CYC_HI = PROG_TIME_HI_MS * 1000 * SYS_CLK_MHZ;
    localparam int PROG_CYC_LO = PROG_TIME_LO_MS * 1000 * SYS_CLK_MHZ;
    localparam int PROG_CNT_W = 22;
    localparam logic [PROG_CNT_W-1:0] PROG_CNT_RST = 22'h000000;

    typedef enum logic [1:0] {TWS_8K, TWS_16K, TWS_32K, TWS_64K} tws_variant_type;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE,
        ST_PROG
    } tws_state_type;

    typedef struct packed {
        logic chip_select_pin_high;
        logic chip_select_pin_mid;
        logic chip_select_pin_low;
    } tws_strap_type;

endpackage : tws_pkg

// [hw/tws_eeprom.sv]
// Two-wire serial memory slave: bus front end, page buffer and array
`timescale 1ns/100ps
module tws_eeprom #(
    parameter tws_pkg::tws_variant_type VARIANT = tws_pkg::TWS_64K,
    parameter int PROG_CYC_HI = tws_pkg::PROG_CYC_HI,
    parameter int PROG_CYC_LO = tws_pkg::PROG_CYC_LO
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Serial bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and control pins
    input wire tws_pkg::tws_strap_type strap,
    input wire logic write_lock,
    input wire logic low_supply,
    // Status
    output logic prog_busy
);

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_s_prev_q;
    logic sda_s_prev_q;
    logic [1:0] tgl_sync_q;
    logic tgl_prev_q;
    logic [1:0] wp_sync_q;
    logic [1:0] lvs_sync_q;
    tws_pkg::tws_strap_type strap_s1_q;
    tws_pkg::tws_strap_type strap_s2_q;
    logic start_ev;
    logic stop_ev;
    logic rise_ev;
    logic [tws_pkg::BYTE_W-1:0] shift_q;
    logic bit_tgl_q;
    logic sda_oe_q;
    logic sda_out_q;
    tws_pkg::tws_state_type state_q;
    logic [tws_pkg::BIT_CNT_W-1:0] cnt_q;
    logic drive_q;
    logic dir_read_q;
    logic [tws_pkg::ADDR_W-1:0] addr_q;
    logic [tws_pkg::BYTE_W-1:0] rd_q;
    logic [tws_pkg::BYTE_W-1:0] page_buf [tws_pkg::PAGE_BYTES];
    logic [tws_pkg::PAGE_BYTES-1:0] buf_valid_q;
    logic [tws_pkg::PROG_CNT_W-1:0] prog_cnt_q;
    logic commit;
    logic busy_q;
    logic [tws_pkg::BYTE_W-1:0] mem [tws_pkg::MEM_WORDS];
    logic [tws_pkg::BYTE_W-1:0] next_byte;
    logic [tws_pkg::ADDR_W-1:0] next_addr;

    function automatic logic [tws_pkg::ADDR_W-1:0] amask(input tws_pkg::tws_variant_type v);
        logic [tws_pkg::ADDR_W-1:0] m;
        m = tws_pkg::MASK_64K;
        if (v == tws_pkg::TWS_8K)
            m = tws_pkg::MASK_8K;
        else if (v == tws_pkg::TWS_16K)
            m = tws_pkg::MASK_16K;
        else if (v == tws_pkg::TWS_32K)
            m = tws_pkg::MASK_32K;
        return m;
    endfunction : amask

    function automatic logic chip_match(input tws_pkg::tws_variant_type v,
                                        input logic [2:0] code,
                                        input tws_pkg::tws_strap_type s);
        logic ok;
        ok = (code == {s.chip_select_pin_high, s.chip_select_pin_mid, s.chip_select_pin_low});
        if (v == tws_pkg::TWS_8K)
            ok = (code[2] == s.chip_select_pin_high);
        else if (v == tws_pkg::TWS_16K)
            ok = 1'b1;
        return ok;
    endfunction : chip_match

    function automatic logic locked(input tws_pkg::tws_variant_type v,
                                    input logic [tws_pkg::ADDR_W-1:0] a);
        logic p;
        p = (a[12:11] == 2'h3);
        if (v == tws_pkg::TWS_8K)
            p = a[9];
        else if (v == tws_pkg::TWS_16K)
            p = a[10];
        else if (v == tws_pkg::TWS_32K)
            p = (a[11:10] == 2'h3);
        return p;
    endfunction : locked

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Link domain: capture on rise, count bits by toggle
    always_ff @(posedge scl)
    begin
        shift_q <= {shift_q[6:0], sda_in};
    end

    always_ff @(posedge scl or negedge rst_n)
    begin
        if (!rst_n)
            bit_tgl_q <= 1'b0;
        else
            bit_tgl_q <= ~bit_tgl_q;
    end

    // Link domain: drive on fall; drive_q updates while the clock is high and is settled by the fall
    always_ff @(negedge scl or negedge rst_n)
    begin
        if (!rst_n)
            sda_oe_q <= 1'b0;
        else
            sda_oe_q <= drive_q;
    end

    always_ff @(negedge scl or negedge rst_n)
    begin
        if (!rst_n)
            sda_out_q <= 1'b0;
        else
            sda_out_q <= 1'b0;
    end

    assign sda_oe = sda_oe_q;
    assign sda_out = sda_out_q;

    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_s_prev_q <= 1'b1;
            sda_s_prev_q <= 1'b1;
            tgl_sync_q <= 2'h0;
            tgl_prev_q <= 1'b0;
            wp_sync_q <= 2'h0;
            lvs_sync_q <= 2'h0;
            strap_s1_q <= '0;
            strap_s2_q <= '0;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], scl};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_s_prev_q <= scl_sync_q[1];
            sda_s_prev_q <= sda_sync_q[1];
            tgl_sync_q <= {tgl_sync_q[0], bit_tgl_q};
            tgl_prev_q <= tgl_sync_q[1];
            wp_sync_q <= {wp_sync_q[0], write_lock};
            lvs_sync_q <= {lvs_sync_q[0], low_supply};
            strap_s1_q <= strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    assign start_ev = scl_sync_q[1] && scl_s_prev_q && sda_s_prev_q && !sda_sync_q[1];
    assign stop_ev = scl_sync_q[1] && scl_s_prev_q && !sda_s_prev_q && sda_sync_q[1];
    assign rise_ev = tgl_sync_q[1] ^ tgl_prev_q;
    assign commit = (state_q == tws_pkg::ST_PROG) && (prog_cnt_q == tws_pkg::PROG_CNT_RST);
    // Next read byte and address, wrapping at the array end
    assign next_byte = mem[addr_q];
    assign next_addr = (addr_q + 13'h0001) & amask(VARIANT);

    // Protocol state machine
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= tws_pkg::ST_IDLE;
            cnt_q <= tws_pkg::BIT_CNT_RST;
            drive_q <= 1'b0;
            dir_read_q <= 1'b0;
            addr_q <= tws_pkg::ADDR_RST;
            rd_q <= 8'h00;
            buf_valid_q <= 32'h00000000;
            prog_cnt_q <= tws_pkg::PROG_CNT_RST;
        end
        else if (state_q == tws_pkg::ST_PROG)
        begin
            drive_q <= 1'b0;
            if (commit)
            begin
                buf_valid_q <= 32'h00000000;
                state_q <= tws_pkg::ST_IDLE;
            end
            else
                prog_cnt_q <= prog_cnt_q - 22'h000001;
        end
        else if (start_ev)
        begin
            state_q <= tws_pkg::ST_DEV;
            cnt_q <= tws_pkg::BIT_CNT_RST;
            drive_q <= 1'b0;
        end
        else if (stop_ev)
        begin
            cnt_q <= tws_pkg::BIT_CNT_RST;
            drive_q <= 1'b0;
            if (state_q == tws_pkg::ST_WDATA && buf_valid_q != 32'h00000000)
            begin
                state_q <= tws_pkg::ST_PROG;
                prog_cnt_q <= lvs_sync_q[1] ? tws_pkg::PROG_CNT_W'(PROG_CYC_LO - 1)
                                            : tws_pkg::PROG_CNT_W'(PROG_CYC_HI - 1);
            end
            else
                state_q <= tws_pkg::ST_IDLE;
        end
        else if (rise_ev && state_q != tws_pkg::ST_IDLE && state_q != tws_pkg::ST_IGNORE)
        begin
            if (cnt_q == tws_pkg::ACK_BIT)
            begin
                cnt_q <= tws_pkg::BIT_CNT_RST;
                drive_q <= 1'b0;
                case (state_q)
                    tws_pkg::ST_DEV:
                    begin
                        // Read fetch never consults the lock pin
                        if (dir_read_q)
                        begin
                            rd_q <= next_byte;
                            drive_q <= ~next_byte[7];
                            addr_q <= next_addr;
                            state_q <= tws_pkg::ST_RDATA;
                        end
                        else if (VARIANT == tws_pkg::TWS_32K || VARIANT == tws_pkg::TWS_64K)
                            state_q <= tws_pkg::ST_ADDR_HI;
                        else
                            state_q <= tws_pkg::ST_ADDR_LO;
                    end
                    tws_pkg::ST_ADDR_HI:
                        state_q <= tws_pkg::ST_ADDR_LO;
                    tws_pkg::ST_ADDR_LO:
                        state_q <= tws_pkg::ST_WDATA;
                    tws_pkg::ST_RDATA:
                    begin
                        if (!shift_q[0])
                        begin
                            rd_q <= next_byte;
                            drive_q <= ~next_byte[7];
                            addr_q <= next_addr;
                        end
                        else
                            state_q <= tws_pkg::ST_IGNORE;
                    end
                    default:
                        state_q <= state_q;
                endcase
            end
            else if (state_q == tws_pkg::ST_RDATA)
            begin
                cnt_q <= cnt_q + 4'h1;
                rd_q <= {rd_q[6:0], 1'b0};
                drive_q <= (cnt_q == tws_pkg::LAST_DATA_BIT) ? 1'b0 : ~rd_q[6];
            end
            else if (cnt_q == tws_pkg::LAST_DATA_BIT)
            begin
                cnt_q <= tws_pkg::ACK_BIT;
                drive_q <= 1'b1;
                case (state_q)
                    tws_pkg::ST_DEV:
                    begin
                        if (shift_q[7:4] == tws_pkg::DEV_TYPE_CODE
                            && chip_match(VARIANT, shift_q[3:1], strap_s2_q))
                        begin
                            dir_read_q <= shift_q[0];
                            buf_valid_q <= shift_q[0] ? buf_valid_q : 32'h00000000;
                            if (VARIANT == tws_pkg::TWS_8K)
                                addr_q[9:8] <= shift_q[2:1];
                            else if (VARIANT == tws_pkg::TWS_16K)
                                addr_q[10:8] <= shift_q[3:1];
                        end
                        else
                        begin
                            drive_q <= 1'b0;
                            state_q <= tws_pkg::ST_IGNORE;
                        end
                    end
                    tws_pkg::ST_ADDR_HI:
                        addr_q <= {shift_q[4:0], addr_q[7:0]} & amask(VARIANT);
                    tws_pkg::ST_ADDR_LO:
                        addr_q[7:0] <= shift_q;
                    tws_pkg::ST_WDATA:
                    begin
                        buf_valid_q[addr_q[4:0]] <= 1'b1;
                        addr_q[4:0] <= addr_q[4:0] + 5'h01;
                    end
                    default:
                        drive_q <= 1'b0;
                endcase
            end
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end

    // Page buffer, overwritten in place on offset wrap
    always_ff @(posedge sys_clk)
    begin
        if (rise_ev && state_q == tws_pkg::ST_WDATA && cnt_q == tws_pkg::LAST_DATA_BIT
            && !start_ev && !stop_ev)
            page_buf[addr_q[4:0]] <= shift_q;
    end

    // Array update at the end of the programming cycle
    always_ff @(posedge sys_clk)
    begin
        if (commit)
        begin
            for (int i = 0; i < tws_pkg::PAGE_BYTES; i++)
            begin
                if (buf_valid_q[i]
                    && !(wp_sync_q[1] && locked(VARIANT, {addr_q[12:5], 5'(i)})))
                    mem[{addr_q[12:5], 5'(i)}] <= page_buf[i];
            end
        end
    end

    // Busy status flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_q <= 1'b0;
        else
            busy_q <= (state_q == tws_pkg::ST_PROG) && !commit;
    end
    assign prog_busy = busy_q;

endmodule : tws_eeprom

// [dv/tws_eeprom_monitor.sv]
// Port checker for the two-wire memory slave
`timescale 1ns/100ps
module tws_eeprom_monitor #(
    parameter int PROG_CYC_LO = 900
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Serial bus
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Pins and status
    input wire tws_pkg::tws_strap_type strap,
    input wire logic write_lock,
    input wire logic low_supply,
    input wire logic prog_busy
);
    localparam int BUSY_MAX = PROG_CYC_LO + 8;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_start;
        scl && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl && $rose(sda_in);
    endsequence
    property p_open_drain; sda_oe |-> sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    property p_oe_on_low; $changed(sda_oe) |-> !scl; endproperty
    a_oe_on_low: assert property (p_oe_on_low) else $error("data moved, clock high");
    property p_oe_stands; $rose(sda_oe) |-> sda_oe [*8]; endproperty
    a_oe_stands: assert property (p_oe_stands) else $error("driven bit too short");
    property p_start_quiet; s_start |-> !sda_oe [*8]; endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
    property p_stop_release; s_stop |=> !sda_oe [*8]; endproperty
    a_stop_release: assert property (p_stop_release) else $error("drive after stop");
    property p_busy_after_stop; $rose(prog_busy) |-> scl && sda_in; endproperty
    a_busy_after_stop: assert property (p_busy_after_stop) else $error("busy, no stop");
    property p_busy_quiet; prog_busy |-> !sda_oe; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
    property p_busy_len; $rose(prog_busy) |-> prog_busy [*8] ##[1:BUSY_MAX] !prog_busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule : tws_eeprom_monitor

bind tws_eeprom tws_eeprom_monitor #(.PROG_CYC_LO(PROG_CYC_LO)) u_mon (
    .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap(strap), .write_lock(write_lock), .low_supply(low_supply),
    .prog_busy(prog_busy)
);

// [dv/tws_master_model.sv]
// Bus master model: drives the serial clock and pulls the data wire
`timescale 1ns/100ps
module tws_master_model (
    // Serial bus
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    localparam int QP = 40;
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task start;
        #1.3;
        #QP sda_oe = 1'b0;
        #QP scl = 1'b1;
        #QP sda_oe = 1'b1;
        #QP scl = 1'b0;
    endtask : start
    task stop;
        #QP sda_oe = 1'b1;
        #QP scl = 1'b1;
        #QP sda_oe = 1'b0;
        #QP;
    endtask : stop
    task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 8; i >= 0; i--)
        begin
            #QP sda_oe = (i > 0) ? !d[i-1] : !ack_in;
            #QP scl = 1'b1;
            #QP ack = sda;
            if (i > 0) q[i-1] = ack;
            #QP scl = 1'b0;
        end
    endtask : xfer
endmodule : tws_master_model

// [dv/two_wire_eeprom_slave_write_path_test.sv]
// Self-checking bench for the two-wire memory slave
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module two_wire_eeprom_slave_write_path_test;
    logic sys_clk;
    logic resetn;
    logic scl;
    logic sda_bus;
    logic m_oe;
    logic sda_out;
    logic sda_oe;
    logic write_lock;
    logic low_supply;
    logic prog_busy;
    logic [7:0] q;
    logic ak;
    int errors;
    int n_tests;
    tws_pkg::tws_strap_type strap;
    logic sda_out8;
    logic sda_oe8;
    logic busy8;
    tws_pkg::tws_strap_type strap8;
    assign sda_bus = !(m_oe || (sda_oe && !sda_out) || (sda_oe8 && !sda_out8));
    always #2 sys_clk = ~sys_clk;
    tws_master_model M (.scl(scl), .sda_oe(m_oe), .sda(sda_bus));
    tws_eeprom #(.PROG_CYC_HI(700), .PROG_CYC_LO(900)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe(sda_oe), .strap(strap), .write_lock(write_lock), .low_supply(low_supply),
        .prog_busy(prog_busy)
    );
    tws_eeprom #(.VARIANT(tws_pkg::TWS_8K), .PROG_CYC_HI(700), .PROG_CYC_LO(900)) DUT8 (
        .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda_bus), .sda_out(sda_out8),
        .sda_oe(sda_oe8), .strap(strap8), .write_lock(write_lock), .low_supply(low_supply),
        .prog_busy(busy8)
    );
    function automatic logic [7:0] dw(input logic [2:0] chip, input logic rw);
        return {tws_pkg::DEV_TYPE_CODE, chip, rw};
    endfunction : dw
    task tally_and_finish;
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task send(input logic [7:0] b, input logic e_ack);
        M.xfer(b, 1'b1, q, ak);
        `CHK("ack", e_ack, ak)
    endtask : send
    task get(input logic [7:0] e, input logic m_ack);
        M.xfer(8'hFF, m_ack, q, ak);
        `CHK("rdata", e, q)
    endtask : get
    task setp(input logic [15:0] a);
        M.start;
        send(dw(3'h5, 1'b0), 1'b0);
        send(a[15:8], 1'b0);
        send(a[7:0], 1'b0);
    endtask : setp
    task wr(input logic [15:0] a, input logic [7:0] d, input int n);
        setp(a);
        for (int i = 0; i < n; i++)
            send(d + 8'(i), 1'b0);
        M.stop;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
        setp(a);
        M.start;
        send(dw(3'h5, 1'b1), 1'b0);
        get(e0, 1'b0);
        get(e1, 1'b1);
        get(8'hFF, 1'b1);
        M.stop;
    endtask : rd
    task wait_done;
        int k;
        k = 0;
        repeat (20) @(negedge sys_clk);
        while ((prog_busy !== 1'b0 || busy8 !== 1'b0) && k < 1100)
        begin
            @(negedge sys_clk);
            k++;
        end
        if (prog_busy !== 1'b0 || busy8 !== 1'b0)
        begin
            errors++;
            tally_and_finish;
        end
    endtask : wait_done
    initial
    begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        strap = tws_pkg::tws_strap_type'(3'h5);
        strap8 = tws_pkg::tws_strap_type'(3'h0);
        write_lock = 1'b0;
        low_supply = 1'b0;
        errors = 0;
        n_tests = 0;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (10) @(negedge sys_clk);
        `CHK("oe_rst", 1'b0, sda_oe)
        wr(16'h001E, 8'hA0, 4);
        repeat (20) @(negedge sys_clk);
        `CHK("busy", 1'b1, prog_busy)
        M.start;
        send(dw(3'h5, 1'b0), 1'b1);
        M.stop;
        wait_done;
        M.start;
        send(dw(3'h5, 1'b0), 1'b0);
        M.stop;
        rd(16'h0000, 8'hA2, 8'hA3);
        rd(16'h001E, 8'hA0, 8'hA1);
        M.start;
        send(dw(3'h4, 1'b0), 1'b1);
        send(8'h00, 1'b1);
        M.stop;
        M.start;
        send({~tws_pkg::DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
        M.stop;
        @(negedge sys_clk);
        low_supply = 1'b1;
        wr(16'h1800, 8'h11, 1);
        repeat (800) @(negedge sys_clk);
        `CHK("busy_lo", 1'b1, prog_busy)
        wait_done;
        low_supply = 1'b0;
        write_lock = 1'b1;
        wr(16'h1800, 8'h22, 1);
        wait_done;
        wr(16'h17FF, 8'h33, 1);
        wait_done;
        rd(16'h17FF, 8'h33, 8'h11);
        @(negedge sys_clk);
        write_lock = 1'b0;
        M.start;
        send(dw(3'h3, 1'b0), 1'b0);
        send(8'h10, 1'b0);
        send(8'h5A, 1'b0);
        M.stop;
        wait_done;
        M.start;
        send(dw(3'h3, 1'b0), 1'b0);
        send(8'h10, 1'b0);
        M.start;
        send(dw(3'h3, 1'b1), 1'b0);
        get(8'h5A, 1'b1);
        M.stop;
        tally_and_finish;
    end
endmodule : two_wire_eeprom_slave_write_path_test
